// *** rtl/usb_cfg_pkg.sv ***
// Constants for the USB configuration defaults and detach register bank.
// Assumes a 40 MHz controller clock and AXI4-Lite access with 32-bit data.
`default_nettype none

package usb_cfg_pkg;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [11:0] ADDR_CFG = 12'h080;
  localparam logic [11:0] ADDR_CTRL = 12'h084;
  localparam logic [11:0] ADDR_DETACH = 12'h088;
  localparam int SCALE_LO = 0;
  localparam int FS_TRIM_LO = 4;
  localparam int LTM_BIT = 8;
  localparam int U1_BIT = 9;
  localparam int HS_TRIM_LO = 12;
  localparam int SOFT_RST_BIT = 0;
  localparam int PROTECT_BIT = 1;
  localparam int TXEQ_BIT = 4;
  localparam int DETACHED_BIT = 8;
  localparam int SS_DET_LO = 16;
  localparam int HS_DET_LO = 0;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [1:0] SCALE_RST = 2'h0;
  localparam logic LTM_DEF = 1'h0;
  localparam logic U1_DEF = 1'h1;
  localparam logic [2:0] TRIM_DEF = 3'h0;
  localparam logic [15:0] SS_DETACH_DEF = 16'h001E;
  localparam logic [15:0] HIGHSPEED_DETACH_MS_DEF = 16'h000A;
  localparam logic PROTECT_RST = 1'h0;
  localparam logic TXEQ_RST = 1'h1;
  ////////////////////////////////////////////////////////////////////////
  localparam int CLK_MHZ = 40;
  localparam int CLK_PERIOD_NS = 25;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = MS_US * CLK_MHZ;
  localparam logic [15:0] TXEQ_SHORT = 16'h0008;
  localparam logic [15:0] TXEQ_FULL = 16'hFFFF;
  localparam int LFPS_SHORT_NS = 100;
  localparam int LFPS_FULL_NS = 1000;
  localparam int WARM_SHORT_US = 30;
  localparam int WARM_FULL_US = 100;
  localparam int LFPS_SHORT_CYC = (LFPS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LFPS_FULL_CYC = (LFPS_FULL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_SHORT_CYC = WARM_SHORT_US * CLK_MHZ;
  localparam int WARM_FULL_CYC = WARM_FULL_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

`default_nettype wire

// *** rtl/detach_timer.sv ***
// Millisecond detach timer: withdraws bus attachment for a loaded count.
// Assumes start is a one-cycle pulse from logic on the same clock.
`default_nettype none

module detach_timer #(
  parameter int MS_CYCLES = usb_cfg_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] duration,
  output logic attach
);
  if (MS_CYCLES < 1) begin : g_bad
    $error("MS_CYCLES must be at least 1");
  end

  typedef enum logic {ATTACHED, DETACHED} det_state_t;

  localparam int DW = $clog2(MS_CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(MS_CYCLES - 1);

  det_state_t state_q;
  logic [DW-1:0] div_q;
  logic [15:0] ms_left_q;
  logic ms_tick;

  assign ms_tick = (div_q == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////
  // A request while already detached is ignored so the window is not stretched.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ATTACHED;
      ms_left_q <= 16'h0000;
      attach <= 1'b1;
    end else begin
      case (state_q)
        ATTACHED: begin
          if (start && duration != 16'h0000) begin
            state_q <= DETACHED;
            ms_left_q <= duration;
            attach <= 1'b0;
          end
        end
        DETACHED: begin
          if (ms_tick) begin
            ms_left_q <= ms_left_q - 16'h0001;
            if (ms_left_q == 16'h0001) begin
              state_q <= ATTACHED;
              attach <= 1'b1;
            end
          end
        end
        default: state_q <= ATTACHED;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_q != DETACHED || ms_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_DETACH_START: assert property (@(posedge clk) disable iff (rst)
    state_q == ATTACHED && start && duration != 16'h0000 |=>
    !attach && ms_left_q == $past(duration))
    else $error("detach did not start with the requested duration");
  AST_ATTACH_ON_EXPIRY: assert property (@(posedge clk) disable iff (rst)
    $rose(attach) |-> $past(ms_left_q) == 16'h0001 && $past(ms_tick))
    else $error("attachment returned before the count expired");
  AST_HOLD_DETACHED: assert property (@(posedge clk) disable iff (rst)
    state_q == DETACHED && !(ms_tick && ms_left_q == 16'h0001) |=> !attach)
    else $error("attachment returned while the count still runs");
  COV_DETACH_DONE: cover property (@(posedge clk) disable iff (rst) $rose(attach));
endmodule

`default_nettype wire

// *** rtl/usb_cfg_bank.sv ***
// USB configuration bank: scale-down decode, loadable defaults, detach control.
// Assumes an AXI4-Lite master on clk and image/reset strobes from same-clock logic.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module usb_cfg_bank #(
  parameter int MS_CYCLES = usb_cfg_pkg::MS_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic image_load,
  input wire logic eeprom_present,
  input wire logic otp_configured,
  input wire logic eep_ltm,
  input wire logic eep_u1,
  input wire logic [2:0] eep_hs_trim,
  input wire logic [2:0] eep_fs_trim,
  input wire logic [15:0] eep_ss_detach,
  input wire logic [15:0] eep_highspeed_detach_ms,
  input wire logic otp_ltm,
  input wire logic otp_u1,
  input wire logic [2:0] otp_hs_trim,
  input wire logic [2:0] otp_fs_trim,
  input wire logic [15:0] otp_ss_detach,
  input wire logic [15:0] otp_highspeed_detach_ms,
  input wire logic usb_bus_reset,
  input wire logic light_reset,
  input wire logic usb_superspeed,
  output logic latency_tolerance_msg_en,
  output logic u1_accept_en,
  output logic [2:0] hs_timeout_trim,
  output logic [2:0] fs_timeout_trim,
  output logic hs_scale_timing,
  output logic hs_scale_suspend,
  output logic ss_txeq_send,
  output logic [15:0] ss_txeq_count,
  output logic [15:0] ss_lfps_burst_cycles,
  output logic [15:0] ss_warm_rx_cycles,
  output logic bus_attach
);
  ////////////////////////////////////////////////////////////////////////
  logic aw_full_q, w_full_q, do_write, bus_rst;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q, cfg_word, ctrl_word, det_word, wr_word;
  logic [3:0] wstrb_q;
  logic [1:0] scale_q;
  logic protect_q, txeq_q, soft_rst_q;
  logic [15:0] ss_det_q, hs_det_q;
  logic img_ltm_q, img_u1_q;
  logic [2:0] img_hs_trim_q, img_fs_trim_q;
  logic [15:0] img_ss_det_q, img_hs_det_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign bus_rst = usb_bus_reset || light_reset;

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[usb_cfg_pkg::SCALE_LO +: 2] = scale_q;
    cfg_word[usb_cfg_pkg::FS_TRIM_LO +: 3] = fs_timeout_trim;
    cfg_word[usb_cfg_pkg::LTM_BIT] = latency_tolerance_msg_en;
    cfg_word[usb_cfg_pkg::U1_BIT] = u1_accept_en;
    cfg_word[usb_cfg_pkg::HS_TRIM_LO +: 3] = hs_timeout_trim;
    ctrl_word = 32'h0000_0000;
    ctrl_word[usb_cfg_pkg::PROTECT_BIT] = protect_q;
    ctrl_word[usb_cfg_pkg::TXEQ_BIT] = txeq_q;
    ctrl_word[usb_cfg_pkg::DETACHED_BIT] = !bus_attach;
    det_word = {ss_det_q, hs_det_q};
    case (waddr_q)
      usb_cfg_pkg::ADDR_CFG: wr_word = merge(cfg_word, wdata_q, wstrb_q);
      usb_cfg_pkg::ADDR_CTRL: wr_word = merge(ctrl_word, wdata_q, wstrb_q);
      default: wr_word = merge(det_word, wdata_q, wstrb_q);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Address and data are held independently, so either may arrive first.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full_q <= 1'b0;
      s_axi_awready <= 1'b1;
      waddr_q <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      s_axi_awready <= 1'b0;
      waddr_q <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_full_q <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_full_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= usb_cfg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (waddr_q == usb_cfg_pkg::ADDR_CFG || waddr_q == usb_cfg_pkg::ADDR_CTRL ||
                      waddr_q == usb_cfg_pkg::ADDR_DETACH) ?
                     usb_cfg_pkg::RESP_OKAY : usb_cfg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= usb_cfg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= usb_cfg_pkg::RESP_OKAY;
      case (s_axi_araddr)
        usb_cfg_pkg::ADDR_CFG: s_axi_rdata <= cfg_word;
        usb_cfg_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_word;
        usb_cfg_pkg::ADDR_DETACH: s_axi_rdata <= det_word;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= usb_cfg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The image registers remember the last EEPROM or OTP image so bus resets can restore it.
  always_ff @(posedge clk) begin
    if (rst) begin
      img_ltm_q <= usb_cfg_pkg::LTM_DEF;
      img_u1_q <= usb_cfg_pkg::U1_DEF;
      img_hs_trim_q <= usb_cfg_pkg::TRIM_DEF;
      img_fs_trim_q <= usb_cfg_pkg::TRIM_DEF;
      img_ss_det_q <= usb_cfg_pkg::SS_DETACH_DEF;
      img_hs_det_q <= usb_cfg_pkg::HIGHSPEED_DETACH_MS_DEF;
    end else if (image_load && eeprom_present) begin
      img_ltm_q <= eep_ltm;
      img_u1_q <= eep_u1;
      img_hs_trim_q <= eep_hs_trim;
      img_fs_trim_q <= eep_fs_trim;
      img_ss_det_q <= eep_ss_detach;
      img_hs_det_q <= eep_highspeed_detach_ms;
    end else if (image_load && otp_configured) begin
      img_ltm_q <= otp_ltm;
      img_u1_q <= otp_u1;
      img_hs_trim_q <= otp_hs_trim;
      img_fs_trim_q <= otp_fs_trim;
      img_ss_det_q <= otp_ss_detach;
      img_hs_det_q <= otp_highspeed_detach_ms;
    end
  end

  // Loadable fields: reset fallback, image load, bus reload, then software.
  always_ff @(posedge clk) begin
    if (rst) begin
      latency_tolerance_msg_en <= usb_cfg_pkg::LTM_DEF;
      u1_accept_en <= usb_cfg_pkg::U1_DEF;
      hs_timeout_trim <= usb_cfg_pkg::TRIM_DEF;
      fs_timeout_trim <= usb_cfg_pkg::TRIM_DEF;
      ss_det_q <= usb_cfg_pkg::SS_DETACH_DEF;
      hs_det_q <= usb_cfg_pkg::HIGHSPEED_DETACH_MS_DEF;
    end else if (image_load) begin
      latency_tolerance_msg_en <= eeprom_present ? eep_ltm :
                                  otp_configured ? otp_ltm : usb_cfg_pkg::LTM_DEF;
      u1_accept_en <= eeprom_present ? eep_u1 : otp_configured ? otp_u1 : usb_cfg_pkg::U1_DEF;
      hs_timeout_trim <= eeprom_present ? eep_hs_trim :
                         otp_configured ? otp_hs_trim : usb_cfg_pkg::TRIM_DEF;
      fs_timeout_trim <= eeprom_present ? eep_fs_trim :
                         otp_configured ? otp_fs_trim : usb_cfg_pkg::TRIM_DEF;
      ss_det_q <= eeprom_present ? eep_ss_detach :
                  otp_configured ? otp_ss_detach : usb_cfg_pkg::SS_DETACH_DEF;
      hs_det_q <= eeprom_present ? eep_highspeed_detach_ms :
                  otp_configured ? otp_highspeed_detach_ms : usb_cfg_pkg::HIGHSPEED_DETACH_MS_DEF;
    end else if (bus_rst) begin
      hs_timeout_trim <= img_hs_trim_q;
      fs_timeout_trim <= img_fs_trim_q;
      if (!protect_q) begin
        latency_tolerance_msg_en <= img_ltm_q;
        u1_accept_en <= img_u1_q;
        ss_det_q <= img_ss_det_q;
        hs_det_q <= img_hs_det_q;
      end
    end else if (do_write && waddr_q == usb_cfg_pkg::ADDR_CFG) begin
      latency_tolerance_msg_en <= wr_word[usb_cfg_pkg::LTM_BIT];
      u1_accept_en <= wr_word[usb_cfg_pkg::U1_BIT];
      hs_timeout_trim <= wr_word[usb_cfg_pkg::HS_TRIM_LO +: 3];
      fs_timeout_trim <= wr_word[usb_cfg_pkg::FS_TRIM_LO +: 3];
    end else if (do_write && waddr_q == usb_cfg_pkg::ADDR_DETACH) begin
      ss_det_q <= wr_word[usb_cfg_pkg::SS_DET_LO +: 16];
      hs_det_q <= wr_word[usb_cfg_pkg::HS_DET_LO +: 16];
    end
  end

  // Selector and control bits follow only the hard reset and software.
  always_ff @(posedge clk) begin
    if (rst) begin
      scale_q <= usb_cfg_pkg::SCALE_RST;
      protect_q <= usb_cfg_pkg::PROTECT_RST;
      txeq_q <= usb_cfg_pkg::TXEQ_RST;
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= do_write && waddr_q == usb_cfg_pkg::ADDR_CTRL &&
                    wr_word[usb_cfg_pkg::SOFT_RST_BIT];
      if (do_write && waddr_q == usb_cfg_pkg::ADDR_CFG) begin
        scale_q <= wr_word[usb_cfg_pkg::SCALE_LO +: 2];
      end
      if (do_write && waddr_q == usb_cfg_pkg::ADDR_CTRL) begin
        protect_q <= wr_word[usb_cfg_pkg::PROTECT_BIT];
        txeq_q <= wr_word[usb_cfg_pkg::TXEQ_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timing decode is registered, so it lags the selector by one cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_scale_timing <= 1'b0;
      hs_scale_suspend <= 1'b0;
      ss_txeq_send <= usb_cfg_pkg::TXEQ_RST;
      ss_txeq_count <= usb_cfg_pkg::TXEQ_FULL;
      ss_lfps_burst_cycles <= 16'(usb_cfg_pkg::LFPS_FULL_CYC);
      ss_warm_rx_cycles <= 16'(usb_cfg_pkg::WARM_FULL_CYC);
    end else begin
      hs_scale_timing <= scale_q[0];
      hs_scale_suspend <= scale_q[1];
      ss_txeq_send <= txeq_q && !scale_q[1];
      ss_txeq_count <= scale_q[1] ? 16'h0000 :
                       scale_q[0] ? usb_cfg_pkg::TXEQ_SHORT : usb_cfg_pkg::TXEQ_FULL;
      ss_lfps_burst_cycles <= scale_q[0] ? 16'(usb_cfg_pkg::LFPS_SHORT_CYC) :
                              16'(usb_cfg_pkg::LFPS_FULL_CYC);
      ss_warm_rx_cycles <= scale_q[0] ? 16'(usb_cfg_pkg::WARM_SHORT_CYC) :
                           16'(usb_cfg_pkg::WARM_FULL_CYC);
    end
  end

  detach_timer #(.MS_CYCLES(MS_CYCLES)) u_detach (
    .clk(clk),
    .rst(rst),
    .start(soft_rst_q),
    .duration(usb_superspeed ? ss_det_q : hs_det_q),
    .attach(bus_attach)
  );

  ////////////////////////////////////////////////////////////////////////
  AST_HS_DECODE: assert property (@(posedge clk) disable iff (rst)
    ##1 hs_scale_timing == $past(scale_q[0]) && hs_scale_suspend == $past(scale_q[1]))
    else $error("high speed scale decode wrong");
  AST_SS_SHORT: assert property (@(posedge clk) disable iff (rst)
    scale_q == 2'h1 |=> ss_txeq_count == 16'h0008 && ss_lfps_burst_cycles == 16'h0004 &&
    ss_warm_rx_cycles == 16'h04B0)
    else $error("SuperSpeed shortened values wrong");
  AST_SS_NO_TXEQ: assert property (@(posedge clk) disable iff (rst)
    scale_q[1] |=> !ss_txeq_send && ss_txeq_count == 16'h0000)
    else $error("equalization sent with selector bit 1 set");
  AST_BOTH: assert property (@(posedge clk) disable iff (rst)
    scale_q == 2'h3 |=> hs_scale_timing && hs_scale_suspend && !ss_txeq_send &&
    ss_lfps_burst_cycles == 16'h0004)
    else $error("selector 11 did not combine both sets");
  AST_RST_VALUES: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> scale_q == 2'h0 && u1_accept_en && !latency_tolerance_msg_en &&
    hs_timeout_trim == 3'h0 && fs_timeout_trim == 3'h0 && ss_det_q == 16'h001E &&
    hs_det_q == 16'h000A)
    else $error("reset values wrong");
  AST_EEPROM_FIRST: assert property (@(posedge clk) disable iff (rst)
    image_load && eeprom_present |=> latency_tolerance_msg_en == $past(eep_ltm) &&
    ss_det_q == $past(eep_ss_detach) && img_hs_det_q == $past(eep_highspeed_detach_ms))
    else $error("EEPROM image not loaded");
  AST_RELOAD: assert property (@(posedge clk) disable iff (rst)
    bus_rst && !image_load |=> fs_timeout_trim == $past(img_fs_trim_q) &&
    hs_timeout_trim == $past(img_hs_trim_q))
    else $error("bus reset did not reload the image");
  AST_PROTECT: assert property (@(posedge clk) disable iff (rst)
    bus_rst && protect_q && !image_load |=> $stable(ss_det_q) && $stable(hs_det_q))
    else $error("protected detach field changed on reset");
  AST_DETACH_SPEED: assert property (@(posedge clk) disable iff (rst)
    soft_rst_q && bus_attach && usb_superspeed && ss_det_q != 16'h0000 |=> !bus_attach)
    else $error("SuperSpeed soft reset did not detach");
  AST_DETACH_HS: assert property (@(posedge clk) disable iff (rst)
    soft_rst_q && bus_attach && !usb_superspeed && hs_det_q != 16'h0000 |=> !bus_attach)
    else $error("high speed soft reset did not detach");
  COV_SCALE_BOTH: cover property (@(posedge clk) disable iff (rst) scale_q == 2'h3);
  COV_RELOAD: cover property (@(posedge clk) disable iff (rst) bus_rst && !protect_q);
  COV_SOFT_RST: cover property (@(posedge clk) disable iff (rst) soft_rst_q && usb_superspeed);
endmodule

`default_nettype wire

// *** verification/usb_cfg_bank_bench.sv ***
// Self-checking bench for the USB configuration bank: registers, images, detach timer.
// Assumes the bank alone on one 40 MHz clock, reached as an AXI4-Lite master would.
`default_nettype none

module usb_cfg_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MSC = 4;
  localparam logic [39:0] FB = {usb_cfg_pkg::LTM_DEF, usb_cfg_pkg::U1_DEF, usb_cfg_pkg::TRIM_DEF,
    usb_cfg_pkg::TRIM_DEF, usb_cfg_pkg::SS_DETACH_DEF, usb_cfg_pkg::HIGHSPEED_DETACH_MS_DEF};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, image_load, eeprom_present;
  logic otp_configured, eep_ltm, eep_u1, otp_ltm, otp_u1, usb_bus_reset, light_reset;
  logic usb_superspeed, latency_tolerance_msg_en, u1_accept_en, hs_scale_timing;
  logic hs_scale_suspend, ss_txeq_send, bus_attach;
  logic [2:0] eep_hs_trim, eep_fs_trim, otp_hs_trim, otp_fs_trim, hs_timeout_trim, fs_timeout_trim;
  logic [15:0] eep_ss_detach, eep_highspeed_detach_ms, otp_ss_detach, otp_highspeed_detach_ms;
  logic [15:0] ss_txeq_count, ss_lfps_burst_cycles, ss_warm_rx_cycles;
  logic [39:0] eimg, oimg, last;
  logic [63:0] r64;
  int fails = 0;
  int tests_run = 0;
  int seed, len;
  assign {eep_ltm, eep_u1, eep_hs_trim, eep_fs_trim, eep_ss_detach, eep_highspeed_detach_ms} = eimg;
  assign {otp_ltm, otp_u1, otp_hs_trim, otp_fs_trim, otp_ss_detach, otp_highspeed_detach_ms} = oimg;
  always #12.5 clk = ~clk;

  usb_cfg_bank #(.MS_CYCLES(MSC)) usb_cfg_bank_i (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .image_load, .eeprom_present, .otp_configured,
    .eep_ltm, .eep_u1, .eep_hs_trim, .eep_fs_trim, .eep_ss_detach, .eep_highspeed_detach_ms, .otp_ltm,
    .otp_u1, .otp_hs_trim, .otp_fs_trim, .otp_ss_detach, .otp_highspeed_detach_ms, .usb_bus_reset,
    .light_reset, .usb_superspeed, .latency_tolerance_msg_en, .u1_accept_en, .hs_timeout_trim,
    .fs_timeout_trim, .hs_scale_timing, .hs_scale_suspend, .ss_txeq_send, .ss_txeq_count,
    .ss_lfps_burst_cycles, .ss_warm_rx_cycles, .bus_attach);

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Each request stands until the edge that samples its ready; a hang is left to the watchdog.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge clk);
    image_load <= (k == 0);
    usb_bus_reset <= (k == 1);
    light_reset <= (k == 2);
    @(posedge clk);
    {image_load, usb_bus_reset, light_reset} <= 3'h0;
    repeat (2) @(posedge clk);
    axi_rd(usb_cfg_pkg::ADDR_DETACH);
    r64 = {24'h0, latency_tolerance_msg_en, u1_accept_en, hs_timeout_trim, fs_timeout_trim, rd};
  endtask

  // Detach length is counted in falling edges while attachment is withdrawn.
  task automatic detach_len(input logic ss);
    int n;
    @(posedge clk);
    usb_superspeed <= ss;
    axi_wr(usb_cfg_pkg::ADDR_CTRL, 32'h00000013);
    for (n = 0; n < 20 && bus_attach !== 1'b0; n++) @(negedge clk);
    for (len = 0; len < 200 && bus_attach === 1'b0; len++) @(negedge clk);
  endtask

  function automatic logic [63:0] dec_exp(input logic [1:0] s);
    logic [15:0] c;
    c = s[1] ? 16'h0000 : (s[0] ? usb_cfg_pkg::TXEQ_SHORT : usb_cfg_pkg::TXEQ_FULL);
    return {13'h0, s[1], s[0], ~s[1], c,
      16'(s[0] ? usb_cfg_pkg::LFPS_SHORT_CYC : usb_cfg_pkg::LFPS_FULL_CYC),
      16'(s[0] ? usb_cfg_pkg::WARM_SHORT_CYC : usb_cfg_pkg::WARM_FULL_CYC)};
  endfunction

  function automatic logic [39:0] img_exp(input logic ep, input logic oc);
    return ep ? eimg : (oc ? oimg : FB);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    final_report();
  end

  initial begin
    seed = 37733;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, image_load, eeprom_present} = '0;
    {otp_configured, usb_bus_reset, light_reset, usb_superspeed, eimg, oimg} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    pulse(3);
    check(r64, {24'h0, FB});
    axi_rd(usb_cfg_pkg::ADDR_CFG);
    check({rd, 31'h0, bus_attach}, {32'h00000200, 32'h00000001});
    check(rsp, usb_cfg_pkg::RESP_OKAY);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      axi_wr(usb_cfg_pkg::ADDR_CFG, 32'(s));
      repeat (2) @(negedge clk);
      check({13'h0, hs_scale_suspend, hs_scale_timing, ss_txeq_send, ss_txeq_count,
        ss_lfps_burst_cycles, ss_warm_rx_cycles}, dec_exp(2'(s)));
    end
    $display("test selector done");
    axi_rd(12'h0FC);
    check({rsp, rd}, {usb_cfg_pkg::RESP_SLVERR, 32'h0});
    axi_wr(12'h0FC, 32'hFFFFFFFF);
    check(rsp, usb_cfg_pkg::RESP_SLVERR);
    axi_wr(usb_cfg_pkg::ADDR_CFG, 32'h00007170);
    axi_wr(usb_cfg_pkg::ADDR_DETACH, 32'h12345678);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      eimg <= 40'({$random(seed), $random(seed)});
      oimg <= 40'({$random(seed), $random(seed)});
      eeprom_present <= (k == 2);
      otp_configured <= (k > 0);
      pulse(0);
      check(r64, {24'h0, img_exp(k == 2, k > 0)});
    end
    last = eimg;
    @(posedge clk);
    eimg <= ~eimg;
    axi_wr(usb_cfg_pkg::ADDR_CFG, 32'h0);
    axi_wr(usb_cfg_pkg::ADDR_DETACH, 32'h00050005);
    pulse(1);
    check(r64, {24'h0, last});
    axi_wr(usb_cfg_pkg::ADDR_CTRL, 32'h00000012);
    check(rsp, usb_cfg_pkg::RESP_OKAY);
    axi_wr(usb_cfg_pkg::ADDR_DETACH, 32'h00030002);
    axi_wr(usb_cfg_pkg::ADDR_CFG, 32'h0);
    pulse(2);
    check(r64, {26'h0, last[37:32], 32'h00030002});
    $display("test image done");
    detach_len(1'b1);
    check(len, 3 * MSC);
    detach_len(1'b0);
    check({bus_attach, len}, {1'b1, 2 * MSC});
    axi_wr(usb_cfg_pkg::ADDR_CTRL, 32'h00000000);
    repeat (2) @(negedge clk);
    check(ss_txeq_send, 1'b0);
    $display("test detach done");
    final_report();
  end
endmodule

`default_nettype wire
